//--- common/dfwm_map.vh
`ifndef DFWM_MAP_VH
`define DFWM_MAP_VH
// Register offsets (byte addresses, one word each)
`define DFWM_OFF_TRIP_MASK   7'h00
`define DFWM_OFF_WARN_MASK   7'h04
`define DFWM_OFF_CONTROL     7'h08
`define DFWM_OFF_STATUS      7'h0c
`define DFWM_OFF_ACTIVE      7'h10
// Reset values
`define DFWM_TRIP_MASK_RST   16'hffff
`define DFWM_WARN_MASK_RST   16'h0000
`define DFWM_LOGIC_OPT_RST   4'h2
// Reserved mask bits 6 and 7
`define DFWM_USED_BITS       16'hff3f
// Condition groups
`define DFWM_CP_GROUP        16'h003f
`define DFWM_VP_GROUP        16'h7f00
// Control register fields
`define DFWM_CTL_CLEAR       0
`define DFWM_CTL_RESET       1
// Bus sag threshold in volts
`define DFWM_SAG_VOLTS       16'h0096
// Ridethrough window
`define DFWM_RT_LIMIT        4'h5
`define DFWM_RT_WINDOW_S     32'd20
`define DFWM_CLK_HZ          32'd200000000
`define DFWM_RT_WINDOW_CYC   (`DFWM_RT_WINDOW_S * `DFWM_CLK_HZ)
// LED codes
`define DFWM_LED_GREEN       2'h0
`define DFWM_LED_GREEN_FL    2'h1
`define DFWM_LED_RED_FL      2'h2
`define DFWM_LED_RED         2'h3
// Stop types
`define DFWM_STOP_NONE       2'h0
`define DFWM_STOP_COAST      2'h1
`define DFWM_STOP_ILIMIT     2'h2
`define DFWM_STOP_RAMP       2'h3
`endif

//--- design/dfwm_manager.v
// Overview of operation
// - LEDs solid green none, flash green warning, flash red soft pin or bit 15, red hard or other masked trip.
// - Hard fault stops drive until full drive reset.
// - Soft fault stops, latched until condition gone and clear-faults.
// - Warning does not stop; held until condition gone and clear.
// - Faults are announced to operator interface; warnings are not.
// - Faults go to fault queue, warnings to warning queue.
// - Non-configurable faults always trip, no mask applies.
// - Status word shown bits 15..8 upper line, 7..0 lower line.
// - Both masks share bit map, bits 0 to 5 are bus conditions.
// - Bus sag when bus voltage falls more than 150V below tracked reference.
// - Excess ridethrough when more than 5 events in 20 seconds.
// - Open circuit when flux-up current below half of commanded.
// - Bit 8 loop input loss, 9-14 port timeouts, 15 comm errors.
// - Mask bits 6 and 7 are reserved.
// - Condition with trip-mask bit set trips the drive.
// - Trips from bits 0-5 light current LED red and coast.
// - Trips from bits 8-14 light velocity LED red, configured stop.
// - Logic option bits 1,2,3 select coast, current limit, ramp.
// - Warning-only condition flashes current LED green, drive runs.
// - Condition clear in both masks is ignored.
// - Masked port timeout never faults.
// - Operator stop key acts as a clear-faults request.
// - Drive reset clears all; clear-faults clears soft and warnings.
`timescale 1ns/1ps
`include "dfwm_map.vh"
module dfwm_manager #(
   parameter        VW         = 16,
   parameter [31:0] RT_WINDOW  = `DFWM_RT_WINDOW_CYC
)(
   input  wire          clock,
   input  wire          srst,
   input  wire          clk_en,
   input  wire [4:0]    avs_address,
   input  wire          avs_read,
   input  wire          avs_write,
   input  wire [31:0]   avs_writedata,
   input  wire [3:0]    avs_byteenable,
   output reg  [31:0]   avs_readdata,
   output wire          avs_waitrequest,
   input  wire [VW-1:0] bus_voltage,
   input  wire [VW-1:0] bus_reference,
   input  wire [VW-1:0] flux_current,
   input  wire [VW-1:0] flux_command,
   input  wire          flux_check,
   input  wire          ridethrough_event,
   input  wire [15:0]   cond_in,
   input  wire          hard_fault_in,
   input  wire          soft_fault_in,
   input  wire          stop_key,
   input  wire          clear_faults_in,
   input  wire          drive_reset_in,
   output reg  [1:0]    current_processor_led,
   output reg  [1:0]    velocity_processor_led,
   output reg           drive_stop,
   output reg  [1:0]    stop_type,
   output reg           oim_fault_announce,
   output reg           fault_queue_push,
   output reg           warn_queue_push,
   output reg  [15:0]   queue_bits,
   output reg  [7:0]    display_upper,
   output reg  [7:0]    display_lower
);

   reg  [15:0] trip_mask_reg;
   reg  [15:0] warn_mask_reg;
   reg  [3:0]  logic_opt_reg;
   reg  [15:0] soft_reg;
   reg  [15:0] warn_reg;
   reg         hard_reg;
   reg         ext_soft_reg;
   reg  [15:0] sync1_reg;
   reg  [15:0] sync2_reg;
   reg  [4:0]  ctl_sync1_reg;
   reg  [4:0]  ctl_sync2_reg;
   reg  [4:0]  ctl_prev_reg;
   reg         hard_prev_reg;
   reg         soft_prev_reg;
   reg  [31:0] rt_timer_reg;
   reg  [3:0]  rt_count_reg;
   reg         rt_over_reg;
   reg         rd_done_reg;
   reg         sw_clear_reg;
   reg         sw_reset_reg;

   wire [15:0] cond_all;
   wire [15:0] trips;
   wire [15:0] warns;
   wire [15:0] new_trip;
   wire [15:0] new_warn;
   wire [VW:0] sag_level;
   wire        sag;
   wire        open_ckt;
   wire        rt_pulse;
   wire        clear_req;
   wire        reset_req;
   wire        hard_rise;
   wire        soft_rise;
   wire        wr_hit;
   wire        rd_hit;

   // Sag: voltage plus threshold below reference; bus voltage and flux
   // values come from logic on this clock and need no synchroniser
   assign sag_level = {1'b0, bus_voltage}
                    + {{(VW+1-16){1'b0}}, `DFWM_SAG_VOLTS};
   assign sag       = sag_level < {1'b0, bus_reference};
   // Open circuit: twice measured below commanded
   assign open_ckt  = flux_check
                    & ({flux_current, 1'b0} < {1'b0, flux_command});

   // Assemble condition vector; reserved bits forced low. Bit 2 of the
   // synchroniser carries the soft fault pin, so bus sag takes its place
   assign cond_all = {sync2_reg[15:8], 2'b00,
                      open_ckt, rt_over_reg, sync2_reg[3],
                      sag, sync2_reg[1:0]}
                     & `DFWM_USED_BITS;

   // Trip has priority over warning; neither bit means ignore
   assign trips = cond_all & trip_mask_reg;
   assign warns = cond_all & warn_mask_reg & ~trip_mask_reg;

   // Announce and push only bits that were not latched yet
   assign new_trip = trips & ~(soft_reg);
   assign new_warn = warns & ~(warn_reg);

   // Rising-edge detectors on the synchronised command pins
   assign rt_pulse  = ctl_sync2_reg[4] & ~ctl_prev_reg[4];
   assign clear_req = (ctl_sync2_reg[0] & ~ctl_prev_reg[0]) | sw_clear_reg
                    | (ctl_sync2_reg[1] & ~ctl_prev_reg[1]);
   assign reset_req = (ctl_sync2_reg[2] & ~ctl_prev_reg[2]) | sw_reset_reg;
   assign hard_rise = ctl_sync2_reg[3] & ~hard_prev_reg;
   assign soft_rise = sync2_reg[2] & ~soft_prev_reg;

   // Access acted on in its wait-state cycle; the master still holds it
   // then, and readdata stands when waitrequest drops
   assign wr_hit = avs_write & ~rd_done_reg;
   assign rd_hit = avs_read & ~rd_done_reg;
   // One wait state on every access
   assign avs_waitrequest = (avs_read | avs_write) & ~rd_done_reg;

   // Two-flop synchronisers for pin inputs
   always @(posedge clock)
   begin
      if (srst)
      begin
         sync1_reg     <= 16'h0000;
         sync2_reg     <= 16'h0000;
         ctl_sync1_reg <= 5'h00;
         ctl_sync2_reg <= 5'h00;
      end
      else if (clk_en)
      begin
         sync1_reg     <= {cond_in[15:3], soft_fault_in, cond_in[1:0]};
         sync2_reg     <= sync1_reg;
         // Command and ridethrough pins share one five-bit synchroniser
         ctl_sync1_reg <= {ridethrough_event, hard_fault_in,
                           drive_reset_in, stop_key, clear_faults_in};
         ctl_sync2_reg <= ctl_sync1_reg;
      end
   end

   // Ridethrough counter over a sliding-restart window
   // The window opens at the first event and closes when it runs out until the next event,
   // so a burst that straddles two windows can go unflagged
   always @(posedge clock)
   begin
      if (srst)
      begin
         rt_timer_reg <= 32'h00000000;
         rt_count_reg <= 4'h0;
         rt_over_reg  <= 1'b0;
      end
      else if (clk_en)
      begin
         if (rt_count_reg != 4'h0 && rt_timer_reg >= RT_WINDOW - 1)
         begin
            rt_timer_reg <= 32'h00000000;
            rt_count_reg <= rt_pulse ? 4'h1 : 4'h0;
         end
         else
         begin
            if (rt_count_reg != 4'h0)
               rt_timer_reg <= rt_timer_reg + 32'h00000001;
            if (rt_pulse && rt_count_reg != 4'hf)
               rt_count_reg <= rt_count_reg + 4'h1;
         end
         rt_over_reg <= rt_count_reg > `DFWM_RT_LIMIT;
      end
   end

   // Fault, warning and hard latches
   always @(posedge clock)
   begin
      if (srst)
      begin
         soft_reg      <= 16'h0000;
         warn_reg      <= 16'h0000;
         hard_reg      <= 1'b0;
         ext_soft_reg  <= 1'b0;
         ctl_prev_reg  <= 5'h00;
         hard_prev_reg <= 1'b0;
         soft_prev_reg <= 1'b0;
      end
      else if (clk_en)
      begin
         ctl_prev_reg  <= ctl_sync2_reg;
         hard_prev_reg <= ctl_sync2_reg[3];
         soft_prev_reg <= sync2_reg[2];
         // Clear releases only conditions that are gone; set wins
         // A condition still present is latched again at once
         if (reset_req)
         begin
            soft_reg     <= trips;
            warn_reg     <= warns;
            ext_soft_reg <= sync2_reg[2];
         end
         else if (clear_req)
         begin
            soft_reg     <= trips;
            warn_reg     <= warns;
            ext_soft_reg <= sync2_reg[2];
         end
         else
         begin
            soft_reg     <= soft_reg | trips;
            warn_reg     <= warn_reg | warns;
            ext_soft_reg <= ext_soft_reg | sync2_reg[2];
         end
         // Hard fault ignores masks and clear-faults
         // and wins over a drive reset in the same cycle
         if (hard_rise || ctl_sync2_reg[3])
            hard_reg <= 1'b1;
         else if (reset_req)
            hard_reg <= 1'b0;
      end
   end

   // Stop reaction, LEDs, announcements and queue pushes
   always @(posedge clock)
   begin
      if (srst)
      begin
         drive_stop             <= 1'b0;
         stop_type              <= `DFWM_STOP_NONE;
         current_processor_led  <= `DFWM_LED_GREEN;
         velocity_processor_led <= `DFWM_LED_GREEN;
         oim_fault_announce     <= 1'b0;
         fault_queue_push       <= 1'b0;
         warn_queue_push        <= 1'b0;
         queue_bits             <= 16'h0000;
      end
      else if (clk_en)
      begin
         drive_stop <= hard_reg | ext_soft_reg | (|soft_reg);
         // Hard faults and current-group trips coast; other faults use configured stop
         if (hard_reg || (soft_reg & `DFWM_CP_GROUP) != 16'h0000)
            stop_type <= `DFWM_STOP_COAST;
         else if ((soft_reg & `DFWM_VP_GROUP) != 16'h0000 ||
                  soft_reg[15] || ext_soft_reg)
         begin
            // Lowest set option bit wins; none set falls back to coast
            if (logic_opt_reg[1])
               stop_type <= `DFWM_STOP_COAST;
            else if (logic_opt_reg[2])
               stop_type <= `DFWM_STOP_ILIMIT;
            else if (logic_opt_reg[3])
               stop_type <= `DFWM_STOP_RAMP;
            else
               stop_type <= `DFWM_STOP_COAST;
         end
         else
            stop_type <= `DFWM_STOP_NONE;
         // Current processor LED
         if (hard_reg || (soft_reg & `DFWM_CP_GROUP) != 16'h0000)
            current_processor_led <= `DFWM_LED_RED;
         else if (ext_soft_reg)
            current_processor_led <= `DFWM_LED_RED_FL;
         else if ((warn_reg & `DFWM_USED_BITS) != 16'h0000)
            current_processor_led <= `DFWM_LED_GREEN_FL;
         else
            current_processor_led <= `DFWM_LED_GREEN;
         // Velocity processor LED
         // Bit 15 alone flashes the velocity lamp red
         if (hard_reg || (soft_reg & `DFWM_VP_GROUP) != 16'h0000)
            velocity_processor_led <= `DFWM_LED_RED;
         else if (soft_reg[15])
            velocity_processor_led <= `DFWM_LED_RED_FL;
         else
            velocity_processor_led <= `DFWM_LED_GREEN;
         // Events: faults announced and queued, warnings only queued
         oim_fault_announce <= (|new_trip) | hard_rise | soft_rise;
         fault_queue_push   <= (|new_trip) | hard_rise | soft_rise;
         warn_queue_push    <= |new_warn;
         if ((|new_trip) | (|new_warn))
            queue_bits <= new_trip | new_warn;
      end
   end

   // Register bus slave
   always @(posedge clock)
   begin
      if (srst)
      begin
         trip_mask_reg  <= `DFWM_TRIP_MASK_RST;
         warn_mask_reg  <= `DFWM_WARN_MASK_RST;
         logic_opt_reg  <= `DFWM_LOGIC_OPT_RST;
         rd_done_reg    <= 1'b0;
         sw_clear_reg   <= 1'b0;
         sw_reset_reg   <= 1'b0;
         avs_readdata   <= 32'h00000000;
         display_upper  <= 8'h00;
         display_lower  <= 8'h00;
      end
      else if (clk_en)
      begin
         // Done flag ends each access after its single wait state
         rd_done_reg  <= (avs_read | avs_write) & ~rd_done_reg;
         sw_clear_reg <= 1'b0;
         sw_reset_reg <= 1'b0;
         // Mask bits 6 and 7 always write as zero
         if (wr_hit)
         begin
            if ({avs_address, 2'b00} == `DFWM_OFF_TRIP_MASK)
            begin
               if (avs_byteenable[0])
                  trip_mask_reg[7:0] <= avs_writedata[7:0] & 8'h3f;
               if (avs_byteenable[1])
                  trip_mask_reg[15:8] <= avs_writedata[15:8];
            end
            else if ({avs_address, 2'b00} == `DFWM_OFF_WARN_MASK)
            begin
               if (avs_byteenable[0])
                  warn_mask_reg[7:0] <= avs_writedata[7:0] & 8'h3f;
               if (avs_byteenable[1])
                  warn_mask_reg[15:8] <= avs_writedata[15:8];
            end
            // Control: byte 0 strobes clear and reset, byte 1 logic options
            else if ({avs_address, 2'b00} == `DFWM_OFF_CONTROL)
            begin
               if (avs_byteenable[0])
               begin
                  sw_clear_reg <= avs_writedata[`DFWM_CTL_CLEAR];
                  sw_reset_reg <= avs_writedata[`DFWM_CTL_RESET];
               end
               if (avs_byteenable[1])
                  logic_opt_reg <= avs_writedata[11:8];
            end
         end
         if (rd_hit)
         begin
            if ({avs_address, 2'b00} == `DFWM_OFF_TRIP_MASK)
               avs_readdata <= {16'h0000, trip_mask_reg};
            else if ({avs_address, 2'b00} == `DFWM_OFF_WARN_MASK)
               avs_readdata <= {16'h0000, warn_mask_reg};
            else if ({avs_address, 2'b00} == `DFWM_OFF_CONTROL)
               avs_readdata <= {20'h00000, logic_opt_reg, 8'h00};
            // Status: warnings in the high half, latched trips in the low
            else if ({avs_address, 2'b00} == `DFWM_OFF_STATUS)
               avs_readdata <= {warn_reg, soft_reg};
            // Active: live conditions with the stop, hard and soft latches
            else if ({avs_address, 2'b00} == `DFWM_OFF_ACTIVE)
               avs_readdata <= {13'h0000, ext_soft_reg, hard_reg,
                                drive_stop, cond_all};
            // Unmapped offsets read as zero
            else
               avs_readdata <= 32'h00000000;
         end
         // Display split: high byte upper line, low byte lower line
         display_upper <= soft_reg[15:8];
         display_lower <= soft_reg[7:0];
      end
   end

endmodule

//--- verification/dfwm_manager_asserts.sv
`timescale 1ns/1ps
module dfwm_manager_asserts (
   input wire        clock,
   input wire        srst,
   input wire        avs_read,
   input wire        avs_write,
   input wire [31:0] avs_readdata,
   input wire        avs_waitrequest,
   input wire [1:0]  current_processor_led,
   input wire [1:0]  velocity_processor_led,
   input wire        drive_stop,
   input wire [1:0]  stop_type,
   input wire        oim_fault_announce
);
   // One clock domain, checks other than reset_clear_a idle while reset is high
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);
   // Bus access: one wait state, then read data held
   access_wait_a: assert property ($rose(avs_read)
      |-> avs_waitrequest)
      else $error("read not stalled on first cycle");
   wait_bound_a: assert property ((avs_read || avs_write)
      && avs_waitrequest |=> !avs_waitrequest)
      else $error("wait state longer than one cycle");
   rdata_hold_a: assert property (!avs_read |=> $stable(avs_readdata))
      else $error("read data changed without a read");
   // Stop reactions tied to the lamp codes
   red_stops_a: assert property ((current_processor_led == 2'h3
      || velocity_processor_led == 2'h3) |-> drive_stop)
      else $error("solid red lamp without stop");
   warn_runs_a: assert property (current_processor_led == 2'h1
      && velocity_processor_led == 2'h0 |-> !drive_stop)
      else $error("warning lamp while drive stopped");
   cp_coast_a: assert property (drive_stop
      && velocity_processor_led == 2'h0
      && current_processor_led == 2'h3 |-> stop_type == 2'h1)
      else $error("current lamp trip without coast");
   vp_stop_a: assert property (velocity_processor_led == 2'h3
      |-> stop_type != 2'h0)
      else $error("velocity lamp trip without stop type");
   // Announcement goes with a stopped drive and lasts one cycle
   announce_stop_a: assert property (oim_fault_announce
      |-> ##[0:2] drive_stop)
      else $error("announcement without a fault stop");
   announce_pulse_a: assert property (oim_fault_announce
      |=> !oim_fault_announce)
      else $error("announcement longer than one cycle");
   // Reset clears stop and lamps
   reset_clear_a: assert property (disable iff (1'b0) srst
      |=> !drive_stop
      && current_processor_led == 2'h0 && velocity_processor_led == 2'h0)
      else $error("outputs not cleared by reset");
endmodule

//--- verification/dfwm_oim_model.sv
`timescale 1ns/1ps
module dfwm_oim_model (
   input  wire       clock,
   input  wire       srst,
   input  wire       announce,
   input  wire       fault_push,
   input  wire       warn_push,
   input  wire       press,
   output reg        stop_key,
   output reg  [7:0] n_ann,
   output reg  [7:0] n_fq,
   output reg  [7:0] n_wq
);
   reg [2:0] hold_reg;
   // Counts announcements and queue entries; a press holds the key 4 cycles
   always @(posedge clock)
   begin
      if (srst)
      begin
         n_ann <= 8'h00;
         n_fq <= 8'h00;
         n_wq <= 8'h00;
         hold_reg <= 3'h0;
         stop_key <= 1'b0;
      end
      else
      begin
         n_ann <= n_ann + {7'h0, announce};
         n_fq <= n_fq + {7'h0, fault_push};
         n_wq <= n_wq + {7'h0, warn_push};
         hold_reg <= press ? 3'h4 : hold_reg - {2'h0, hold_reg != 3'h0};
         stop_key <= press || hold_reg > 3'h1;
      end
   end
endmodule

//--- verification/drive_fault_warning_manager_tb.sv
`timescale 1ns/1ps
module drive_fault_warning_manager_tb;
   reg         clock = 1'b0;
   reg         srst = 1'b1;
   reg  [4:0]  avs_address = 5'h00;
   reg         avs_read = 1'b0;
   reg         avs_write = 1'b0;
   reg  [31:0] avs_writedata = 32'h0;
   reg  [15:0] bus_voltage = 16'h0200;
   reg         flux_check = 1'b0;
   reg  [15:0] cond_in = 16'h0000;
   reg         hard_fault_in = 1'b0;
   reg         soft_fault_in = 1'b0;
   reg         clear_faults_in = 1'b0;
   reg         drive_reset_in = 1'b0;
   reg         press = 1'b0;
   reg         clk_en = 1'b1;
   reg         ridethrough_event = 1'b0;
   wire [31:0] avs_readdata;
   wire        avs_waitrequest, stop_key, drive_stop, ann, fq, wq;
   wire [1:0]  cp_led, vp_led, stop_type;
   wire [7:0]  n_ann, n_fq, n_wq, upper, lower;
   wire [15:0] qbits;
   integer     n_mismatch = 0;
   integer     samples_checked = 0;
   integer     i;
   // Core clock, 5 ns period
   initial
   forever #2.5 clock = ~clock;
   dfwm_manager #(.RT_WINDOW(32'd100)) dfwm_manager_inst (
      .clock(clock), .srst(srst), .clk_en(clk_en),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(4'hf), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .bus_voltage(bus_voltage),
      .bus_reference(16'h0200), .flux_current(16'h0007),
      .flux_command(16'h0010), .flux_check(flux_check),
      .ridethrough_event(ridethrough_event), .cond_in(cond_in),
      .hard_fault_in(hard_fault_in), .soft_fault_in(soft_fault_in),
      .stop_key(stop_key), .clear_faults_in(clear_faults_in),
      .drive_reset_in(drive_reset_in), .current_processor_led(cp_led),
      .velocity_processor_led(vp_led), .drive_stop(drive_stop),
      .stop_type(stop_type), .oim_fault_announce(ann),
      .fault_queue_push(fq), .warn_queue_push(wq), .queue_bits(qbits),
      .display_upper(upper), .display_lower(lower));
   dfwm_oim_model dfwm_oim_model_inst (
      .clock(clock), .srst(srst), .announce(ann), .fault_push(fq),
      .warn_push(wq), .press(press), .stop_key(stop_key),
      .n_ann(n_ann), .n_fq(n_fq), .n_wq(n_wq));
   // Compare and count
   task chk(input [63:0] nm, input [31:0] seen, input [31:0] exp);
   begin
      samples_checked = samples_checked + 1;
      if (seen !== exp)
      begin
         n_mismatch = n_mismatch + 1;
         $display("FAIL %0s expected %h seen %h", nm, exp, seen);
      end
   end
   endtask
   task idle(input integer n);
      repeat (n) @(posedge clock);
   endtask
   // Hold the request until waitrequest is sampled low
   task ack;
      integer k;
   begin
      k = 0;
      @(posedge clock);
      while (avs_waitrequest !== 1'b0 && k < 20)
      begin
         k = k + 1;
         @(posedge clock);
      end
      if (k == 20)
         chk("timeout", 1, 0);
   end
   endtask
   task wr(input [4:0] a, input [31:0] d);
   begin
      @(posedge clock);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      ack;
      avs_write <= 1'b0;
   end
   endtask
   task rd(input [4:0] a, input [31:0] e);
   begin
      @(posedge clock);
      avs_address <= a;
      avs_read <= 1'b1;
      ack;
      chk("readdata", avs_readdata, e);
      avs_read <= 1'b0;
   end
   endtask
   task outs(input [1:0] cp, input [1:0] vp, input st, input [1:0] ty);
   begin
      idle(8);
      chk("cp_led", {30'h0, cp_led}, {30'h0, cp});
      chk("vp_led", {30'h0, vp_led}, {30'h0, vp});
      chk("stop", {31'h0, drive_stop}, {31'h0, st});
      chk("stoptype", {30'h0, stop_type}, {30'h0, ty});
   end
   endtask
   task clr_pin;
   begin
      clear_faults_in <= 1'b1;
      idle(3);
      clear_faults_in <= 1'b0;
   end
   endtask
   task end_of_test;
   begin
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask
   // Watchdog against a hung bus or sequence
   initial
   begin
      idle(20000);
      n_mismatch = n_mismatch + 1;
      end_of_test;
   end
   // Main sequence
   initial
   begin
      idle(2);
      srst <= 1'b0;
      rd(5'h00, 32'h0000ffff);
      rd(5'h01, 32'h0);
      wr(5'h01, 32'hffff);
      rd(5'h01, 32'h0000ff3f);
      rd(5'h07, 32'h0);
      $display("registers done");
      cond_in <= 16'h0002;
      outs(2'h3, 2'h0, 1'b1, 2'h1);
      chk("announce", n_ann, 1);
      chk("faultlog", n_fq, 1);
      wr(5'h02, 32'h0201);
      outs(2'h3, 2'h0, 1'b1, 2'h1);
      cond_in <= 16'h0;
      wr(5'h02, 32'h0201);
      outs(2'h0, 2'h0, 1'b0, 2'h0);
      $display("trip done");
      wr(5'h00, 32'hfff7);
      cond_in <= 16'h0008;
      outs(2'h1, 2'h0, 1'b0, 2'h0);
      chk("announce", n_ann, 1);
      chk("warnlog", n_wq, 1);
      chk("qbits", qbits, 32'h0008);
      cond_in <= 16'h0;
      outs(2'h1, 2'h0, 1'b0, 2'h0);
      press <= 1'b1;
      idle(1);
      press <= 1'b0;
      outs(2'h0, 2'h0, 1'b0, 2'h0);
      wr(5'h00, 32'h0);
      wr(5'h01, 32'h0);
      cond_in <= 16'hffff;
      outs(2'h0, 2'h0, 1'b0, 2'h0);
      chk("faultlog", n_fq, 1);
      cond_in <= 16'h0;
      wr(5'h00, 32'h7f00);
      $display("warning done");
      for (i = 0; i < 3; i = i + 1)
      begin
         wr(5'h02, {20'h0, 4'h2 << i, 8'h00});
         cond_in <= 16'h0200 << i;
         outs(2'h0, 2'h3, 1'b1, i + 1);
         chk("upper", upper, 8'h02 << i);
         rd(5'h03, {16'h0, 16'h0200 << i});
         cond_in <= 16'h0;
         wr(5'h02, {20'h0, 4'h2 << i, 8'h01});
         outs(2'h0, 2'h0, 1'b0, 2'h0);
      end
      $display("stop types done");
      wr(5'h00, 32'hffff);
      wr(5'h01, 32'hffff);
      bus_voltage <= 16'h016a;
      outs(2'h0, 2'h0, 1'b0, 2'h0);
      bus_voltage <= 16'h0169;
      outs(2'h3, 2'h0, 1'b1, 2'h1);
      chk("lower", lower, 32'h04);
      chk("qbits", qbits, 32'h0004);
      bus_voltage <= 16'h0200;
      clr_pin;
      outs(2'h0, 2'h0, 1'b0, 2'h0);
      flux_check <= 1'b1;
      outs(2'h3, 2'h0, 1'b1, 2'h1);
      flux_check <= 1'b0;
      clr_pin;
      outs(2'h0, 2'h0, 1'b0, 2'h0);
      // Frozen clock enable: a condition seen meanwhile never latches
      clk_en <= 1'b0;
      cond_in <= 16'h0002;
      outs(2'h0, 2'h0, 1'b0, 2'h0);
      cond_in <= 16'h0000;
      clk_en <= 1'b1;
      outs(2'h0, 2'h0, 1'b0, 2'h0);
      // Five ridethroughs stay quiet, the sixth trips within the window
      for (i = 0; i < 6; i = i + 1)
      begin
         ridethrough_event <= 1'b1;
         idle(1);
         ridethrough_event <= 1'b0;
         idle(1);
         if (i == 4)
            outs(2'h0, 2'h0, 1'b0, 2'h0);
      end
      outs(2'h3, 2'h0, 1'b1, 2'h1);
      chk("lower", lower, 32'h10);
      idle(100);
      clr_pin;
      outs(2'h0, 2'h0, 1'b0, 2'h0);
      soft_fault_in <= 1'b1;
      idle(8);
      chk("cp_led", {30'h0, cp_led}, 32'h2);
      chk("stop", {31'h0, drive_stop}, 32'h1);
      soft_fault_in <= 1'b0;
      clr_pin;
      idle(8);
      chk("stop", {31'h0, drive_stop}, 32'h0);
      $display("analog and soft done");
      wr(5'h00, 32'h0);
      hard_fault_in <= 1'b1;
      idle(8);
      chk("stop", {31'h0, drive_stop}, 32'h1);
      hard_fault_in <= 1'b0;
      clr_pin;
      idle(8);
      chk("stop", {31'h0, drive_stop}, 32'h1);
      drive_reset_in <= 1'b1;
      idle(3);
      drive_reset_in <= 1'b0;
      idle(8);
      chk("stop", {31'h0, drive_stop}, 32'h0);
      chk("announce", n_ann, 9);
      $display("hard fault done");
      end_of_test;
   end
endmodule
bind dfwm_manager dfwm_manager_asserts dfwm_manager_asserts_inst (
   .clock(clock), .srst(srst), .avs_read(avs_read),
   .avs_write(avs_write), .avs_readdata(avs_readdata),
   .avs_waitrequest(avs_waitrequest),
   .current_processor_led(current_processor_led),
   .velocity_processor_led(velocity_processor_led),
   .drive_stop(drive_stop), .stop_type(stop_type),
   .oim_fault_announce(oim_fault_announce));
